// ===== acs_defines.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the conversion sequencer; definitions only, included by bare name.
 */
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ==========================================================================
// register byte offsets
`define ACS_OFF_SC1       12'h000
`define ACS_OFF_SC2       12'h004
`define ACS_OFF_CFG       12'h008
`define ACS_OFF_CVH       12'h00C
`define ACS_OFF_CVL       12'h010
`define ACS_OFF_RH        12'h014
`define ACS_OFF_RL        12'h018
`define ACS_OFF_STAT      12'h01C

// ==========================================================================
// status_control_one fields
`define ACS_SC1_CH_LSB    0
`define ACS_SC1_CH_MSB    4
`define ACS_SC1_CONT      5
`define ACS_SC1_IEN       6
`define ACS_SC1_DONE      7
// status_control_two fields
`define ACS_SC2_CFGT      4
`define ACS_SC2_CMPEN     5
`define ACS_SC2_HWTRG     6
`define ACS_SC2_ACTIVE    7
// converter_config_reg fields
`define ACS_CFG_ICLK_LSB  0
`define ACS_CFG_ICLK_MSB  1
`define ACS_CFG_MODE_LSB  2
`define ACS_CFG_MODE_MSB  3
`define ACS_CFG_LSMP      4
`define ACS_CFG_DIV_LSB   5
`define ACS_CFG_DIV_MSB   6
`define ACS_CFG_LPC       7

// ==========================================================================
// reset values and field codes
`define ACS_RST_SC1       8'h1F
`define ACS_RST_SC2       8'h00
`define ACS_RST_CFG       8'h00
`define ACS_MODE_8BIT     2'h0
`define ACS_MODE_10BIT    2'h2
`define ACS_ICLK_ASYNC    2'h3

// ==========================================================================
// timing, in conversion clock cycles unless noted
`define ACS_SAMPLE_SHORT  3
`define ACS_SAMPLE_LONG   23
`define ACS_SAR_8BIT      9
`define ACS_SAR_10BIT     11
`define ACS_FIRST_EXTRA   5
`define ACS_BUS_OVERHEAD  5
`define ACS_ASYNC_START_NS 5000
`define ACS_CLK_PERIOD_NS  5

`endif

// ===== acs_clock_divider.v
/*
 * conversion clock enable generator: picks a source tick and divides it.
 * assumes all inputs are on mclk; alternate and async ticks already synchronised.
 */
`timescale 1ns/1ps

module acs_clock_divider (
    // clock and reset
    input  wire       mclk,
    input  wire       srst,
    // control
    input  wire       run,
    input  wire [1:0] inputClockSelect,
    input  wire [1:0] clockDivideSelect,
    input  wire       altTick,
    input  wire       asyncTick,
    // output
    output reg        convTick
);

    reg        halfBus;
    reg  [2:0] divCount;
    reg        srcTick;
    wire [2:0] divLimit;

    // ==========================================================================
    // source select
    always @* begin
        case (inputClockSelect)
            2'h0:    srcTick = 1'b1;
            2'h1:    srcTick = halfBus;
            2'h2:    srcTick = altTick;
            default: srcTick = asyncTick;
        endcase
    end

    assign divLimit = (3'h1 << clockDivideSelect) - 3'h1;

    // divider held cleared while idle so every start from idle is aligned
    always @(posedge mclk) begin
        if (srst || !run) begin
            halfBus  <= 1'b0;
            divCount <= 3'h0;
            convTick <= 1'b0;
        end else begin
            halfBus  <= ~halfBus;
            convTick <= 1'b0;
            if (srcTick) begin
                if (divCount >= divLimit) begin
                    divCount <= 3'h0;
                    convTick <= 1'b1;
                end else begin
                    divCount <= divCount + 3'h1;
                end
            end
        end
    end

endmodule

// ===== acs_sequencer.v
/*
 * conversion sequencer with an AXI4-Lite register slave on mclk.
 * assumes the analog core returns a raw code when asked; pins from outside pass two flops.
 */
// Functional notes
// - converts at 8-bit or 10-bit resolution per mode field
// - software trigger: write to first control register starts unless channel all ones
// - hardware trigger: a trigger input rising edge starts a conversion instead
// - continuous enable restarts after each transfer until aborted
// - transfer sets complete flag; irq raised when enable high
// - 10-bit high read pending low read blocks transfer, discards result
// - single compare-false conversion ignores blocking and stops
// - otherwise blocked transfer immediately starts another conversion
// - first control register write aborts, then restarts with software trigger selected unless channel all ones
// - writes to second control, config or compare registers abort
// - reset or stop without async clock aborts conversion
// - abort leaves result registers unchanged
// - idle until started; async clock enabled only when selected and started
// - sample short or long, then approximate, then transfer
// - first conversion 17/19/37/39 conversion cycles plus 5 bus cycles
// - async source adds up to 5 us startup on first conversion
// - later continuous conversions take 12/14/32/34 conversion cycles
// - compare adds two's complement of compare value, stores sum
// - compare false: no flag, no result update
// - wait mode finishes conversions and accepts triggers, irq wakes
// - converter disabled in reset or with channel all ones
// - 10-bit result spans both bytes; 8-bit only low byte
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer #(
    parameter ASYNC_START_CYCLES = (`ACS_ASYNC_START_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire        mclk,
    input  wire        srst,
    // axi4-lite write address and data
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // triggers, power modes and clock ticks from outside
    input  wire        hwTriggerInput,
    input  wire        stopMode,
    input  wire        waitMode,
    input  wire        alternateClock,
    input  wire        asyncClockTick,
    // analog core
    input  wire [10:0] rawCode,
    output reg         sampleEnable,
    output reg         convertEnable,
    output reg  [4:0]  channelSelect,
    output reg         asyncClockEnable,
    output reg         lowPowerSelect,
    // interrupt
    output wire        completeIrq
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_START  = 2'h1;
    localparam ST_SAMPLE = 2'h2;
    localparam ST_SAR    = 2'h3;

    // phase lengths as plain integers, cut to the counter width where used
    localparam SMP_SHORT = `ACS_SAMPLE_SHORT;
    localparam SMP_LONG  = `ACS_SAMPLE_LONG;
    localparam SAR_8     = `ACS_SAR_8BIT;
    localparam SAR_10    = `ACS_SAR_10BIT;
    localparam FIRST_ADD = `ACS_FIRST_EXTRA;

    // ==========================================================================
    // registers
    reg  [7:0]  sc1;
    reg  [7:0]  sc2;
    reg  [7:0]  cfg;
    reg  [1:0]  cvHigh;
    reg  [7:0]  cvLow;
    reg  [9:0]  result;
    reg         blocking;
    reg  [1:0]  state;
    reg  [7:0]  phaseCount;
    reg  [12:0] startCount;
    reg         firstConv;
    reg         active;
    reg  [2:0]  syncTrig;
    reg  [1:0]  syncStop;
    reg  [1:0]  syncAlt;
    reg  [1:0]  syncAsync;
    reg  [1:0]  syncWait;
    reg         altPrev;
    reg         asyncPrev;
    reg         awHeld;
    reg         wHeld;
    reg  [11:0] awAddr;
    reg  [31:0] wData;
    reg  [3:0]  wStrb;
    reg         doneSync;
    reg  [10:0] convCode;
    wire        convTick;

    wire [1:0]  mode      = cfg[`ACS_CFG_MODE_MSB:`ACS_CFG_MODE_LSB];
    wire        is10      = (mode == `ACS_MODE_10BIT);
    wire        asyncSel  = (cfg[`ACS_CFG_ICLK_MSB:`ACS_CFG_ICLK_LSB] == `ACS_ICLK_ASYNC);
    wire        chanOff   = &sc1[`ACS_SC1_CH_MSB:`ACS_SC1_CH_LSB];
    wire        trigRise  = syncTrig[1] & ~syncTrig[2];
    wire        wrFire    = awHeld & wHeld & ~s_axi_bvalid;
    wire        wrLane0   = wrFire & wStrb[0];
    wire [9:0]  wrWord    = awAddr[11:2];

    // one-hot decode of an address against a register offset
    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr[11:2] == off[11:2]);
        end
    endfunction

    // rounded result at the active resolution
    function [9:0] roundCode;
        input [10:0] raw;
        input        ten;
        begin
            if (ten)
                roundCode = (raw[10:1] == 10'h3FF) ? 10'h3FF : raw[10:1] + {9'h0, raw[0]};
            else
                roundCode = (raw[10:3] == 8'hFF) ? 10'h0FF : {2'h0, raw[10:3] + {7'h0, raw[2]}};
        end
    endfunction

    wire wrSc1   = wrLane0 && hit(awAddr, `ACS_OFF_SC1);
    wire wrOther = wrLane0 && (hit(awAddr, `ACS_OFF_SC2) || hit(awAddr, `ACS_OFF_CFG) ||
                   hit(awAddr, `ACS_OFF_CVH) || hit(awAddr, `ACS_OFF_CVL));
    wire stopAbort = syncStop[1] & ~asyncSel;
    wire abort     = wrSc1 | wrOther | stopAbort;

    // ==========================================================================
    // input synchronisers: first stage read only by second
    always @(posedge mclk) begin
        if (srst) begin
            syncTrig  <= 3'h0;
            syncStop  <= 2'h0;
            syncAlt   <= 2'h0;
            syncAsync <= 2'h0;
            syncWait  <= 2'h0;
            altPrev   <= 1'b0;
            asyncPrev <= 1'b0;
        end else begin
            syncTrig  <= {syncTrig[1:0], hwTriggerInput};
            syncStop  <= {syncStop[0], stopMode};
            syncAlt   <= {syncAlt[0], alternateClock};
            syncAsync <= {syncAsync[0], asyncClockTick};
            syncWait  <= {syncWait[0], waitMode};
            altPrev   <= syncAlt[1];
            asyncPrev <= syncAsync[1];
        end
    end

    acs_clock_divider u_div (
        .mclk              (mclk),
        .srst              (srst),
        .run               (active),
        .inputClockSelect  (cfg[`ACS_CFG_ICLK_MSB:`ACS_CFG_ICLK_LSB]),
        .clockDivideSelect (cfg[`ACS_CFG_DIV_MSB:`ACS_CFG_DIV_LSB]),
        .altTick           (syncAlt[1] & ~altPrev),
        .asyncTick         (syncAsync[1] & ~asyncPrev),
        .convTick          (convTick)
    );

    // ==========================================================================
    // axi write channel: address and data taken in either order
    assign s_axi_awready = ~awHeld;
    assign s_axi_wready  = ~wHeld;

    always @(posedge mclk) begin
        if (srst) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 12'h000;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrWord <= 10'h007) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // conversion sequencer
    wire [7:0] sampleLen = cfg[`ACS_CFG_LSMP] ? SMP_LONG[7:0] : SMP_SHORT[7:0];
    wire [7:0] sarLen    = is10 ? SAR_10[7:0] : SAR_8[7:0];
    wire [9:0] rounded   = roundCode(convCode, is10);
    wire [9:0] cmpValue  = is10 ? {cvHigh, cvLow} : {2'h0, cvLow};
    // add two's complement of the compare value
    wire [10:0] cmpSum   = {1'b0, rounded} + {1'b1, ~cmpValue} + 11'h001;
    wire        sumNeg   = cmpSum[10];
    wire        cmpTrue  = sc2[`ACS_SC2_CFGT] ? ~sumNeg : sumNeg;
    wire        cmpOn    = sc2[`ACS_SC2_CMPEN];
    wire [9:0]  storeVal = cmpOn ? (is10 ? cmpSum[9:0] : {2'h0, cmpSum[7:0]}) : rounded;
    wire        cont     = sc1[`ACS_SC1_CONT];
    // start on software write or trigger edge
    wire swStart   = wrSc1 && !sc2[`ACS_SC2_HWTRG] && !(&wData[4:0]);
    wire hwStart   = trigRise && sc2[`ACS_SC2_HWTRG] && !chanOff && !active;
    // high read done, low read pending
    wire blocked   = blocking && is10;
    wire readRl    = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `ACS_OFF_RL);
    wire readRh    = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `ACS_OFF_RH);

    always @(posedge mclk) begin
        if (srst) begin
            state            <= ST_IDLE;
            active           <= 1'b0;
            phaseCount       <= 8'h00;
            startCount       <= 13'h0000;
            firstConv        <= 1'b0;
            doneSync         <= 1'b0;
            convCode         <= 11'h000;
            sampleEnable     <= 1'b0;
            convertEnable    <= 1'b0;
            asyncClockEnable <= 1'b0;
            sc1              <= `ACS_RST_SC1;
            sc2              <= `ACS_RST_SC2;
            cfg              <= `ACS_RST_CFG;
            cvHigh           <= 2'h0;
            cvLow            <= 8'h00;
            result           <= 10'h000;
            blocking         <= 1'b0;
        end else begin
            doneSync <= 1'b0;
            // register writes; one process owns sc1 and sc2 so status bits have one driver
            if (wrLane0) begin
                if (hit(awAddr, `ACS_OFF_SC1))
                    sc1[6:0] <= wData[6:0];
                if (hit(awAddr, `ACS_OFF_SC2))
                    sc2[6:4] <= wData[6:4];
                if (hit(awAddr, `ACS_OFF_CFG))
                    cfg <= wData[7:0];
                if (hit(awAddr, `ACS_OFF_CVH))
                    cvHigh <= wData[1:0];
                if (hit(awAddr, `ACS_OFF_CVL))
                    cvLow <= wData[7:0];
            end
            if (readRl)
                blocking <= 1'b0;
            else if (readRh && is10)
                blocking <= 1'b1;
            if (abort) begin
                state            <= ST_IDLE;
                active           <= 1'b0;
                sampleEnable     <= 1'b0;
                convertEnable    <= 1'b0;
                asyncClockEnable <= 1'b0;
                sc2[7]           <= 1'b0;
                if (wrSc1 || wrOther)
                    blocking <= 1'b0;
                if (wrSc1)
                    sc1[7] <= 1'b0;
                if (swStart && !stopAbort) begin
                    state     <= ST_START;
                    active    <= 1'b1;
                    sc2[7]    <= 1'b1;
                    firstConv <= 1'b1;
                end
            end else begin
                if (readRl)
                    sc1[7] <= 1'b0;
                case (state)
                    ST_IDLE: begin
                        // idle until started, off when channel all ones
                        if (hwStart) begin
                            state     <= ST_START;
                            active    <= 1'b1;
                            sc2[7]    <= 1'b1;
                            firstConv <= 1'b1;
                        end
                    end
                    ST_START: begin
                        // async generator start-up on first conversion
                        asyncClockEnable <= asyncSel;
                        phaseCount       <= 8'h00;
                        if (asyncSel && firstConv && startCount < ASYNC_START_CYCLES[12:0]) begin
                            startCount <= startCount + 13'h0001;
                        end else begin
                            startCount   <= 13'h0000;
                            state        <= ST_SAMPLE;
                            sampleEnable <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        // sample for short or long period
                        if (convTick) begin
                            if (phaseCount + 8'h01 >= sampleLen + (firstConv ? FIRST_ADD[7:0] : 8'h00)) begin
                                phaseCount    <= 8'h00;
                                sampleEnable  <= 1'b0;
                                convertEnable <= 1'b1;
                                state         <= ST_SAR;
                            end else begin
                                phaseCount <= phaseCount + 8'h01;
                            end
                        end
                    end
                    default: begin
                        if (convTick) begin
                            if (phaseCount + 8'h01 >= sarLen) begin
                                convertEnable <= 1'b0;
                                convCode      <= rawCode;
                                doneSync      <= 1'b1;
                                state         <= ST_IDLE;
                            end else begin
                                phaseCount <= phaseCount + 8'h01;
                            end
                        end
                    end
                endcase
                // transfer one bus cycle after converter done
                if (doneSync) begin
                    firstConv <= 1'b0;
                    if (cmpOn && !cmpTrue && !cont) begin
                        active           <= 1'b0;
                        sc2[7]           <= 1'b0;
                        asyncClockEnable <= 1'b0;
                    end else if (blocked) begin
                        state <= ST_START;
                    end else if (cmpOn && !cmpTrue) begin
                        state <= ST_START;
                    end else begin
                        result <= storeVal;
                        sc1[7] <= 1'b1;
                        if (cont) begin
                            state <= ST_START;
                        end else begin
                            active           <= 1'b0;
                            sc2[7]           <= 1'b0;
                            asyncClockEnable <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // interrupt also wakes from wait mode
    assign completeIrq = sc1[`ACS_SC1_DONE] & sc1[`ACS_SC1_IEN];

    // ==========================================================================
    // analog side controls
    always @(posedge mclk) begin
        if (srst) begin
            channelSelect  <= 5'h1F;
            lowPowerSelect <= 1'b0;
        end else begin
            channelSelect  <= sc1[4:0];
            lowPowerSelect <= cfg[`ACS_CFG_LPC];
        end
    end

    // ==========================================================================
    // axi read channel: one cycle to data
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge mclk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0000_0000;
            if (hit(s_axi_araddr, `ACS_OFF_SC1))
                s_axi_rdata[7:0] <= sc1;
            else if (hit(s_axi_araddr, `ACS_OFF_SC2))
                s_axi_rdata[7:0] <= {sc2[7:4], 4'h0};
            else if (hit(s_axi_araddr, `ACS_OFF_CFG))
                s_axi_rdata[7:0] <= cfg;
            else if (hit(s_axi_araddr, `ACS_OFF_CVH))
                s_axi_rdata[7:0] <= {6'h00, cvHigh};
            else if (hit(s_axi_araddr, `ACS_OFF_CVL))
                s_axi_rdata[7:0] <= cvLow;
            else if (hit(s_axi_araddr, `ACS_OFF_RH))
                s_axi_rdata[7:0] <= {6'h00, result[9:8]};
            else if (hit(s_axi_araddr, `ACS_OFF_RL))
                s_axi_rdata[7:0] <= result[7:0];
            else if (hit(s_axi_araddr, `ACS_OFF_STAT))
                s_axi_rdata[7:0] <= {4'h0, syncWait[1], blocking, state};
            else
                s_axi_rresp <= 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== acs_sequencer_properties.sv
/* port checker for the conversion sequencer.
   assumes a bind to acs_sequencer and one clock. */
`timescale 1ns/1ps
module acs_seq_props (
    // clock and reset
    input wire       mclk,
    input wire       srst,
    // bus handshakes
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    // converter phases
    input wire       sampleEnable,
    input wire       convertEnable,
    input wire [4:0] channelSelect,
    input wire       completeIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ====================
    // bus answers: one each, no new read while one stands
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    read_gap_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    // ====================
    // converter phases
    off_idle_a: assert property (channelSelect == 5'h1F |-> !sampleEnable && !convertEnable) else $error("runs off");
    phase_excl_a: assert property (!(sampleEnable && convertEnable)) else $error("phases overlap");
    sample_first_a: assert property ($rose(convertEnable) |-> $past(sampleEnable)) else $error("no sample");
    sample_bound_a: assert property ($rose(sampleEnable) |-> ##[1:60] !sampleEnable) else $error("long sample");
    approx_bound_a: assert property ($rose(convertEnable) |-> ##[1:20] !convertEnable) else $error("long approx");
    cover property ($rose(completeIrq));
    cover property ($rose(convertEnable));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind acs_sequencer acs_seq_props u_p (.mclk(mclk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sampleEnable(sampleEnable), .convertEnable(convertEnable),
    .channelSelect(channelSelect), .completeIrq(completeIrq));

// ===== acs_sequencer_test.sv
/* bench for the conversion sequencer over axi4-lite.
   assumes bus clock as conversion clock, divide by one. */
`timescale 1ns/1ps
module acs_sequencer_test;
    reg         mclk = 1'b0;
    reg         srst = 1'b1;
    reg         rdy = 1'b1;
    reg         awValid = 1'b0;
    reg         wValid = 1'b0;
    reg         arValid = 1'b0;
    reg         hwTrig = 1'b0;
    reg         stopPin = 1'b0;
    reg         waitPin = 1'b0;
    reg  [11:0] awAddr = 12'h000;
    reg  [11:0] arAddr = 12'h000;
    reg  [7:0]  wData = 8'h00;
    reg  [10:0] raw = 11'h000;
    wire        awReady, wReady, bValid, arReady, rValid, irq;
    wire [1:0]  bResp;
    wire [31:0] rData;
    integer     errorCnt = 0;
    integer     compares = 0;
    // short async startup keeps runs brief
    acs_sequencer #(.ASYNC_START_CYCLES(4)) dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata({24'h000000, wData}),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(rdy), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(), .s_axi_rvalid(rValid),
        .s_axi_rready(rdy), .hwTriggerInput(hwTrig), .stopMode(stopPin), .waitMode(waitPin),
        .alternateClock(1'b0), .asyncClockTick(1'b0), .rawCode(raw), .sampleEnable(),
        .convertEnable(), .channelSelect(), .asyncClockEnable(), .lowPowerSelect(), .completeIrq(irq));
    initial forever #2.5 mclk = ~mclk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                errorCnt = errorCnt + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input [11:0] a, input [7:0] d, input [1:0] r);
        begin
            awAddr <= a;
            wData <= d;
            awValid <= 1'b1;
            wValid <= 1'b1;
            do begin
                @(posedge mclk);
                if (awValid && awReady) awValid <= 1'b0;
                if (wValid && wReady) wValid <= 1'b0;
            end while (bValid !== 1'b1);
            chk({30'h0, bResp}, {30'h0, r});
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            arAddr <= a;
            arValid <= 1'b1;
            do begin
                @(posedge mclk);
                if (arValid && arReady) arValid <= 1'b0;
            end while (rValid !== 1'b1);
            chk(rData, e);
        end
    endtask
    task waitIrq;
        while (irq !== 1'b1) @(posedge mclk);
    endtask
    // longer than the slowest conversion plus synchroniser
    task settle;
        repeat (80) @(posedge mclk);
    endtask
    task endSim;
        begin
            if (errorCnt == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        errorCnt = errorCnt + 1;
        endSim;
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(12'h000, 32'h1F);
        wr(12'h020, 8'h00, 2'h2);
        raw <= 11'h5A4;
        wr(12'h008, 8'h08, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        waitIrq;
        rd(12'h000, 32'hC1);
        rd(12'h014, 32'h02);
        rd(12'h018, 32'hD2);
        raw <= 11'h13C;
        wr(12'h000, 8'h41, 2'h0);
        rd(12'h014, 32'h02);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd(12'h018, 32'hD2);
        waitIrq;
        rd(12'h018, 32'h9E);
        raw <= 11'h040;
        wr(12'h000, 8'h41, 2'h0);
        wr(12'h010, 8'h00, 2'h0);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd(12'h018, 32'h9E);
        wr(12'h004, 8'h30, 2'h0);
        wr(12'h010, 8'h10, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        waitIrq;
        rd(12'h018, 32'h10);
        wr(12'h010, 8'h40, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        settle;
        rd(12'h004, 32'h30);
        rd(12'h018, 32'h10);
        wr(12'h004, 8'h20, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        waitIrq;
        rd(12'h014, 32'h03);
        rd(12'h018, 32'hE0);
        wr(12'h004, 8'h40, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        settle;
        chk({31'h0, irq}, 32'h0);
        hwTrig <= 1'b1;
        waitIrq;
        hwTrig <= 1'b0;
        rd(12'h018, 32'h20);
        wr(12'h004, 8'h00, 2'h0);
        wr(12'h000, 8'h61, 2'h0);
        waitIrq;
        rd(12'h018, 32'h20);
        waitIrq;
        wr(12'h000, 8'h1F, 2'h0);
        settle;
        rd(12'h004, 32'h00);
        wr(12'h000, 8'h41, 2'h0);
        stopPin <= 1'b1;
        waitPin <= 1'b1;
        settle;
        chk({31'h0, irq}, 32'h0);
        rd(12'h004, 32'h00);
        rd(12'h01C, 32'h08);
        stopPin <= 1'b0;
        rd(12'h018, 32'h20);
        raw <= 11'h0A4;
        wr(12'h008, 8'h00, 2'h0);
        wr(12'h000, 8'h41, 2'h0);
        waitIrq;
        rd(12'h018, 32'h15);
        rd(12'h014, 32'h00);
        endSim;
    end
endmodule
